/* File: hw/stc_regs.vh */
`ifndef STC_REGS_VH
`define STC_REGS_VH
// Byte addresses of the word-aligned registers
`define STC_ADDR_COUNT_LOW 5'h00
`define STC_ADDR_COUNT_HIGH 5'h04
`define STC_ADDR_CONTROL 5'h08
`define STC_ADDR_STATUS 5'h0C
`define STC_ADDR_MASK 5'h10
// Control field positions
`define STC_CTL_RUN 0
`define STC_CTL_SRC 1
`define STC_CTL_NOSYNC 2
`define STC_CTL_OSCEN 3
`define STC_CTL_PS_LO 4
`define STC_CTL_PS_HI 5
`define STC_CTL_WIDE 7
// Writable control bits; bit 6 reads zero
`define STC_CTL_WMASK 8'hBF
`define STC_CTL_RESET 8'h00
// Status and mask: overflow in bit 0
`define STC_ST_OVF 0
`define STC_ST_RESET 8'h00
`define STC_MASK_RESET 8'h00
// Count wrap points
`define STC_COUNT_MAX 16'hFFFF
`define STC_COUNT_ZERO 16'h0000
// Instruction cycle length in clocks
`define STC_INSTR_CLOCKS 4
`endif

/* File: hw/stc_timer.v */
// Contract
// RULE1: Sixteen-bit count held as low and high bytes
// RULE2: Software reads and writes both count bytes
// RULE3: Source bit picks instruction clock or external
// RULE4: Count external rising edges or instruction cycles
// RULE5: Overflow event when count wraps to zero
// RULE6: Special event trigger clears the count
// RULE7: Count only while run bit is set
// RULE8: Prescale 1:1, 1:2, 1:4, 1:8 from bits 5-4
// RULE9: Oscillator inverter runs only when enabled
// RULE10: Control bit 6 reads zero, ignores writes
// RULE11: Wide mode: high address hits buffer, low read loads it
// RULE12: Wide mode: low write loads high from buffer
// RULE13: Bit 2 bypasses external clock synchronisation
//
// Decided for this implementation: the Avalon-MM slave port and the register addresses.
`timescale 1ns/10ps
`include "stc_regs.vh"

module stc_timer #(
   parameter INSTR_CLOCKS = `STC_INSTR_CLOCKS
) (
   // Clock and reset
   input wire clock_i,
   input wire rst_i,
   // Avalon-MM slave
   input wire [4:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   input wire [3:0] avs_byteenable_i,
   output wire [31:0] avs_readdata_o,
   output wire avs_waitrequest_o,
   // External count clock and oscillator pins
   input wire ext_clk_i,
   input wire osc_in_i,
   output wire osc_drive_o,
   output wire osc_enable_o,
   // Special event trigger from the capture/compare module
   input wire event_trigger_i,
   // Events
   output wire overflow_o,
   output wire irq_o
);

   reg [7:0] count_low_reg;
   reg [7:0] count_high_reg;
   reg [7:0] high_buffer_reg;
   reg [7:0] control_reg;
   reg [7:0] status_reg;
   reg [7:0] mask_reg;
   reg [2:0] prescale_reg;
   reg [7:0] instr_cnt_reg;
   reg instr_tick_reg;
   reg src_level_reg;
   reg pending_reg;
   reg wait_reg;
   reg [31:0] readdata_reg;
   reg overflow_reg;
   reg irq_reg;
   reg osc_drive_reg;
   reg osc_enable_reg;

   wire [15:0] count_now;
   wire access;
   wire do_read;
   wire do_write;
   wire wr_low;
   wire wr_high;
   wire rd_low;
   wire wide;
   wire [1:0] pin_raw;
   wire [1:0] pin_sync;
   wire selected_pin;
   wire ext_edge;
   wire src_tick;
   wire pre_carry;
   wire count_tick;
   wire wrap;
   wire [2:0] ps_mask;

   function hit;
      input [4:0] addr;
      input [4:0] target;
      begin
         hit = (addr == target);
      end
   endfunction

   assign count_now = {count_high_reg, count_low_reg}; // RULE1
   assign wide = control_reg[`STC_CTL_WIDE];

   // Bus request served once, in the cycle wait_reg is still high
   assign access = (avs_read_i | avs_write_i) & wait_reg;
   assign do_read = access & avs_read_i;
   assign do_write = access & avs_write_i & avs_byteenable_i[0];
   assign wr_low = do_write & hit(avs_address_i, `STC_ADDR_COUNT_LOW);
   assign wr_high = do_write & hit(avs_address_i, `STC_ADDR_COUNT_HIGH);
   assign rd_low = do_read & hit(avs_address_i, `STC_ADDR_COUNT_LOW);

   // Both pins idle low, so no false edge follows reset
   assign pin_raw = {osc_in_i, ext_clk_i};
   // Source is picked after the synchronisers, never on the raw pins
   assign selected_pin = control_reg[`STC_CTL_OSCEN] ? pin_sync[1] : pin_sync[0];
   assign ext_edge = selected_pin & ~src_level_reg; // RULE4

   // Synchronised mode aligns edges to the instruction cycle
   assign src_tick = ~control_reg[`STC_CTL_SRC] ? instr_tick_reg : // RULE3
      (control_reg[`STC_CTL_NOSYNC] ? ext_edge : // RULE13
      ((ext_edge | pending_reg) & instr_tick_reg));

   // Ratio becomes a mask of prescaler bits that must all be set
   function [2:0] prescale_mask;
      input [1:0] ratio_sel;
      begin
         case (ratio_sel)
            2'b00: prescale_mask = 3'h0;
            2'b01: prescale_mask = 3'h1;
            2'b10: prescale_mask = 3'h3;
            default: prescale_mask = 3'h7;
         endcase
      end
   endfunction

   assign ps_mask = prescale_mask({control_reg[`STC_CTL_PS_HI],
      control_reg[`STC_CTL_PS_LO]}); // RULE8
   assign pre_carry = ((prescale_reg & ps_mask) == ps_mask); // RULE8
   assign count_tick = control_reg[`STC_CTL_RUN] & src_tick & pre_carry; // RULE7
   assign wrap = count_tick & (count_now == `STC_COUNT_MAX); // RULE5

   // Instruction cycle strobe
   always @(posedge clock_i) begin
      if (rst_i) begin
         instr_cnt_reg <= 8'h00;
         instr_tick_reg <= 1'b0;
      end else if (instr_cnt_reg == INSTR_CLOCKS[7:0] - 8'h01) begin
         instr_cnt_reg <= 8'h00;
         instr_tick_reg <= 1'b1;
      end else begin
         instr_cnt_reg <= instr_cnt_reg + 8'h01;
         instr_tick_reg <= 1'b0;
      end
   end

   // Each pin passes two flops before any logic reads it
   // Index 0 is the count pin, index 1 the oscillator input
   genvar pin_idx;
   generate
      for (pin_idx = 0; pin_idx < 2; pin_idx = pin_idx + 1) begin : g_pin_sync
         reg meta_reg;
         reg sync_reg;
         always @(posedge clock_i) begin
            if (rst_i) begin
               meta_reg <= 1'b0;
               sync_reg <= 1'b0;
            end else begin
               meta_reg <= pin_raw[pin_idx];
               sync_reg <= meta_reg;
            end
         end
         assign pin_sync[pin_idx] = sync_reg;
      end
   endgenerate

   // Previous level of the chosen source for edge detection
   // Both synchronised pins idle low, so switching source is glitch free
   always @(posedge clock_i) begin
      if (rst_i) begin
         src_level_reg <= 1'b0;
      end else begin
         src_level_reg <= selected_pin;
      end
   end

   // Edge seen between instruction cycles waits for the next one
   always @(posedge clock_i) begin
      if (rst_i) begin
         pending_reg <= 1'b0;
      end else if (instr_tick_reg | control_reg[`STC_CTL_NOSYNC]) begin
         pending_reg <= 1'b0;
      end else if (ext_edge) begin
         pending_reg <= 1'b1;
      end
   end

   // Prescaler; cleared only by a low byte write
   always @(posedge clock_i) begin
      if (rst_i) begin
         prescale_reg <= 3'h0;
      end else if (wr_low) begin
         prescale_reg <= 3'h0;
      end else if (control_reg[`STC_CTL_RUN] & src_tick) begin
         prescale_reg <= pre_carry ? 3'h0 : prescale_reg + 3'h1; // RULE8
      end
   end

   // Count: software write beats the trigger, trigger beats counting
   always @(posedge clock_i) begin
      if (rst_i) begin
         count_low_reg <= 8'h00;
         count_high_reg <= 8'h00;
      end else begin
         if (wr_low) begin
            count_low_reg <= avs_writedata_i[7:0]; // RULE2
            if (wide) begin
               count_high_reg <= high_buffer_reg; // RULE12
            end
         end else if (event_trigger_i) begin
            // Trigger leaves the prescaler running; only low writes clear it
            count_low_reg <= 8'h00; // RULE6
            if (!(wr_high & ~wide)) begin
               count_high_reg <= 8'h00;
            end
         end else if (count_tick) begin
            {count_high_reg, count_low_reg} <= count_now + 16'h0001; // RULE4
         end
         if (wr_high & ~wide) begin
            count_high_reg <= avs_writedata_i[7:0]; // RULE2
         end
      end
   end

   // High byte buffer for atomic sixteen-bit access
   // Avoids a torn read when the low byte rolls over between accesses
   always @(posedge clock_i) begin
      if (rst_i) begin
         high_buffer_reg <= 8'h00;
      end else if (wr_high & wide) begin
         high_buffer_reg <= avs_writedata_i[7:0]; // RULE11
      end else if (rd_low & wide) begin
         high_buffer_reg <= count_high_reg; // RULE11
      end
   end

   // Control, mask and sticky status
   always @(posedge clock_i) begin
      if (rst_i) begin
         control_reg <= `STC_CTL_RESET;
         mask_reg <= `STC_MASK_RESET;
         status_reg <= `STC_ST_RESET;
      end else begin
         if (do_write & hit(avs_address_i, `STC_ADDR_CONTROL)) begin
            control_reg <= avs_writedata_i[7:0] & `STC_CTL_WMASK; // RULE10
         end
         if (do_write & hit(avs_address_i, `STC_ADDR_MASK)) begin
            mask_reg <= avs_writedata_i[7:0] & 8'h01;
         end
         // Set wins over a write-one clear in the same cycle
         if (wrap) begin
            status_reg[`STC_ST_OVF] <= 1'b1; // RULE5
         end else if (do_write & hit(avs_address_i, `STC_ADDR_STATUS) &
               avs_writedata_i[`STC_ST_OVF]) begin
            status_reg[`STC_ST_OVF] <= 1'b0;
         end
      end
   end

   // Bus answer: waitrequest drops for one cycle after the request
   // One fixed wait state keeps read data straight from a flop
   // Trade-off: every access costs two cycles, even back to back
   always @(posedge clock_i) begin
      if (rst_i) begin
         wait_reg <= 1'b1;
         readdata_reg <= 32'h00000000;
      end else begin
         wait_reg <= ~access;
         if (do_read) begin
            case (avs_address_i)
               `STC_ADDR_COUNT_LOW: readdata_reg <= {24'h000000, count_low_reg};
               `STC_ADDR_COUNT_HIGH: readdata_reg <= {24'h000000,
                  wide ? high_buffer_reg : count_high_reg}; // RULE11
               `STC_ADDR_CONTROL: readdata_reg <= {24'h000000, control_reg};
               `STC_ADDR_STATUS: readdata_reg <= {24'h000000, status_reg};
               `STC_ADDR_MASK: readdata_reg <= {24'h000000, mask_reg};
               default: readdata_reg <= 32'h00000000;
            endcase
         end
      end
   end

   // Events, interrupt and oscillator pins
   always @(posedge clock_i) begin
      if (rst_i) begin
         overflow_reg <= 1'b0;
         irq_reg <= 1'b0;
         osc_drive_reg <= 1'b0;
         osc_enable_reg <= 1'b0;
      end else begin
         overflow_reg <= wrap; // RULE5
         irq_reg <= |(status_reg & mask_reg);
         // Inverter held off when disabled to save power
         osc_enable_reg <= control_reg[`STC_CTL_OSCEN]; // RULE9
         // Inverter sees the pin only after its synchroniser
         osc_drive_reg <= control_reg[`STC_CTL_OSCEN] & ~pin_sync[1]; // RULE9
      end
   end

   assign avs_readdata_o = readdata_reg;
   assign avs_waitrequest_o = wait_reg;
   assign overflow_o = overflow_reg;
   assign irq_o = irq_reg;
   assign osc_drive_o = osc_drive_reg;
   assign osc_enable_o = osc_enable_reg;

endmodule // stc_timer

/* File: test/stc_timer_asserts.sv */
`timescale 1ns/10ps
module stc_timer_asserts (
   // Watched ports
   input wire clock_i,
   input wire rst_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_readdata_o,
   input wire avs_waitrequest_o,
   input wire osc_in_i,
   input wire osc_drive_o,
   input wire osc_enable_o,
   input wire overflow_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   AST_WAIT_ANSWER: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
      |=> !avs_waitrequest_o) else $error("request not answered");
   AST_WAIT_ONE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("answer too long");
   AST_WAIT_CAUSE: assert property (!avs_waitrequest_o |-> $past(avs_read_i || avs_write_i))
      else $error("answer without request");
   AST_RDATA_HIGH: assert property (avs_readdata_o[31:8] == 24'h000000)
      else $error("read data above byte");
   AST_OVF_GAP: assert property (overflow_o |=> !overflow_o [*8])
      else $error("overflow too close");
   AST_OSC_OFF: assert property (!osc_enable_o && !$past(osc_enable_o) |-> !osc_drive_o)
      else $error("inverter drives while off");
   AST_OSC_INV: assert property (osc_enable_o && $past(osc_enable_o)
      |-> osc_drive_o == !$past(osc_in_i, 3)) else $error("inverter output wrong");
   AST_RESET_IDLE: assert property ($fell(rst_i) |-> avs_waitrequest_o && !overflow_o)
      else $error("outputs busy after reset");
endmodule // stc_timer_asserts

bind stc_timer stc_timer_asserts u_asserts (.clock_i(clock_i), .rst_i(rst_i),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o), .osc_in_i(osc_in_i), .osc_drive_o(osc_drive_o),
   .osc_enable_o(osc_enable_o), .overflow_o(overflow_o));

/* File: test/stc_host.sv */
`timescale 1ns/10ps
module stc_host (
   // Bus master side
   input wire clock_i,
   input wire wait_i,
   input wire [31:0] rdata_i,
   output logic [4:0] addr_o,
   output logic read_o,
   output logic write_o,
   output logic [31:0] wdata_o
);
   initial {addr_o, read_o, write_o, wdata_o} = '0;
   // Request held until the edge that sees wait low
   task bus(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge clock_i);
      addr_o <= a;
      read_o <= !w;
      write_o <= w;
      wdata_o <= {24'h000000, d};
      do @(posedge clock_i); while (wait_i !== 1'b0);
      q = rdata_i[7:0];
      read_o <= 1'b0;
      write_o <= 1'b0;
   endtask
endmodule // stc_host

/* File: test/testbench.sv */
`timescale 1ns/10ps
module testbench;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic ext_clk = 1'b0;
   logic osc_in = 1'b0;
   logic trig = 1'b0;
   logic [4:0] addr;
   logic rd, wr, wq, osc_drv, osc_en, ovf, irq;
   logic [31:0] wd, rdat;
   logic [7:0] q, held;
   int miscompares = 0;
   int compares = 0;
   // Address, write data, expected readback
   logic [20:0] rows [0:6] = '{{5'h08, 8'hFE, 8'hBE}, {5'h08, 8'h40, 8'h00},
      {5'h00, 8'h34, 8'h34}, {5'h04, 8'h12, 8'h12}, {5'h10, 8'h01, 8'h01},
      {5'h14, 8'h5A, 8'h00}, {5'h08, 8'h00, 8'h00}};
   logic [7:0] modes [0:2] = '{8'h07, 8'h03, 8'h0F};
   always #10 clock_i = ~clock_i;
   stc_host host (.clock_i(clock_i), .wait_i(wq), .rdata_i(rdat), .addr_o(addr),
      .read_o(rd), .write_o(wr), .wdata_o(wd));
   stc_timer #(.INSTR_CLOCKS(2)) DUT (.clock_i(clock_i), .rst_i(rst_i), .avs_address_i(addr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wq), .ext_clk_i(ext_clk), .osc_in_i(osc_in),
      .osc_drive_o(osc_drv), .osc_enable_o(osc_en), .event_trigger_i(trig),
      .overflow_o(ovf), .irq_o(irq));
   task chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Start and stop edges of a run are only known to a tick or two
   task near(input logic [7:0] got, input int exp);
      compares++;
      if ((got + 2 >= exp && got <= exp + 2) !== 1'b1) begin
         miscompares++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task wr_reg(input logic [4:0] a, input logic [7:0] d);
      host.bus(1'b1, a, d, q);
   endtask
   task rd_reg(input logic [4:0] a);
      host.bus(1'b0, a, 8'h00, q);
   endtask
   task give_verdict;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      #1000000;
      miscompares++;
      give_verdict;
   end
   initial begin
      repeat (3) @(posedge clock_i);
      rst_i <= 1'b0;
      for (int a = 0; a < 6; a++) begin
         rd_reg(5'(a * 4));
         chk(q, 8'h00);
      end
      foreach (rows[i]) begin
         wr_reg(rows[i][20:16], rows[i][15:8]);
         rd_reg(rows[i][20:16]);
         chk(q, rows[i][7:0]);
      end
      wr_reg(5'h08, 8'h80);
      wr_reg(5'h04, 8'h56);
      rd_reg(5'h04);
      chk(q, 8'h56);
      rd_reg(5'h00);
      rd_reg(5'h04);
      chk(q, 8'h12);
      wr_reg(5'h04, 8'h56);
      wr_reg(5'h00, 8'h78);
      wr_reg(5'h08, 8'h00);
      rd_reg(5'h04);
      chk(q, 8'h56);
      for (int p = 0; p < 4; p++) begin
         wr_reg(5'h00, 8'h00);
         wr_reg(5'h08, 8'(p * 16 + 1));
         repeat (128) @(posedge clock_i);
         wr_reg(5'h08, 8'h00);
         rd_reg(5'h00);
         near(q, 131 / (2 << p));
      end
      held = q;
      repeat (20) @(posedge clock_i);
      rd_reg(5'h00);
      chk(q, held);
      wr_reg(5'h04, 8'hFF);
      wr_reg(5'h00, 8'hFE);
      wr_reg(5'h08, 8'h01);
      for (int i = 0; i < 40 && ovf !== 1'b1; i++) @(posedge clock_i);
      repeat (3) @(posedge clock_i);
      chk({7'h00, irq}, 8'h01);
      wr_reg(5'h08, 8'h00);
      rd_reg(5'h0C);
      chk(q, 8'h01);
      wr_reg(5'h0C, 8'h01);
      rd_reg(5'h0C);
      chk({q[6:0], irq}, 8'h00);
      wr_reg(5'h00, 8'h33);
      @(posedge clock_i) trig <= 1'b1;
      @(posedge clock_i) trig <= 1'b0;
      rd_reg(5'h00);
      chk(q, 8'h00);
      foreach (modes[m]) begin
         wr_reg(5'h00, 8'h00);
         wr_reg(5'h08, modes[m]);
         repeat (20) begin
            repeat (4) @(posedge clock_i);
            {osc_in, ext_clk} <= {osc_in ^ modes[m][3], ext_clk ^ !modes[m][3]};
         end
         repeat (8) @(posedge clock_i);
         wr_reg(5'h08, 8'h00);
         rd_reg(5'h00);
         chk(q, 8'h0A);
      end
      give_verdict;
   end
endmodule // testbench
